// [pkg/act_regs.svh]
`ifndef ACT_REGS_SVH
`define ACT_REGS_SVH
// ****************************************
// widths and constants
// ****************************************
`define ACT_CNT_W 16
`define ACT_CH 4
`define ACT_DT_W 8
`define ACT_CNT_ZERO 16'h0000
`define ACT_CNT_ONE 16'h0001
`define ACT_DT_ZERO 8'h00
`define ACT_DT_ONE 8'h01
`define ACT_CH_ZERO 4'h0
`endif

// [pkg/act_pkg.sv]
`include "act_regs.svh"
package act_pkg;
    // ****************************************
    // modes and states
    // ****************************************
    typedef enum logic [1:0] {
        ACT_MODE_UP = 2'h0,
        ACT_MODE_DOWN = 2'h1,
        ACT_MODE_CENTRE = 2'h2,
        ACT_MODE_ENCODER = 2'h3
    } act_mode_type;

    typedef enum logic [1:0] {
        ACT_SLAVE_OFF = 2'h0,
        ACT_SLAVE_RESET = 2'h1,
        ACT_SLAVE_GATE = 2'h2,
        ACT_SLAVE_START = 2'h3
    } act_slave_type;

    // gray path run -> force -> hold; hold -> run flips both bits
    typedef enum logic [1:0] {
        ACT_BRK_RUN = 2'h0,
        ACT_BRK_FORCE = 2'h1,
        ACT_BRK_HOLD = 2'h3
    } act_brk_type;

    typedef struct packed {
        logic brk_s1;
        logic brk_s2;
        logic trg_s1;
        logic trg_s2;
        logic trg_prev;
        logic [`ACT_CH-1:0] cap_s1;
        logic [`ACT_CH-1:0] cap_s2;
        logic [`ACT_CH-1:0] cap_prev;
        logic [`ACT_CNT_W-1:0] psc;
        logic [`ACT_CNT_W-1:0] cnt;
        logic dir;
        logic started;
        act_brk_type brk;
        logic [`ACT_CH-1:0][`ACT_CNT_W-1:0] cap_val;
        logic [`ACT_CH-1:0] pwm;
        logic [`ACT_CH-1:0] irq_cc;
        logic irq_upd;
        logic irq_brk;
        logic trig;
    } act_state_type;

    typedef struct packed {
        logic ref_prev;
        logic [`ACT_DT_W-1:0] cnt;
        logic main;
        logic comp;
    } act_dt_state_type;
endpackage

// [design/act_deadtime.sv]
`timescale 1ns/1ps
`default_nettype none
`include "act_regs.svh"
module act_deadtime (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ref_i,
    input wire logic [`ACT_DT_W-1:0] dt_i,
    input wire logic force_i,
    input wire logic safe_main_i,
    input wire logic safe_comp_i,
    output logic main_o,
    output logic comp_o
);
    act_pkg::act_dt_state_type st_reg;
    act_pkg::act_dt_state_type st_next;

    always_comb begin
        st_next = st_reg;
        st_next.ref_prev = ref_i;
        if (force_i) begin
            // safe level wins; dead time reloads so release is clean
            st_next.main = safe_main_i;
            st_next.comp = safe_comp_i;
            st_next.cnt = dt_i;
        end else if (ref_i != st_reg.ref_prev) begin
            st_next.cnt = dt_i;
            st_next.main = (dt_i == `ACT_DT_ZERO) & ref_i;
            st_next.comp = (dt_i == `ACT_DT_ZERO) & ~ref_i;
        end else if (st_reg.cnt != `ACT_DT_ZERO) begin
            st_next.cnt = st_reg.cnt - `ACT_DT_ONE;
            st_next.main = (st_reg.cnt == `ACT_DT_ONE) & ref_i;
            st_next.comp = (st_reg.cnt == `ACT_DT_ONE) & ~ref_i;
        end else begin
            st_next.main = ref_i;
            st_next.comp = ~ref_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign main_o = st_reg.main;
    assign comp_o = st_reg.comp;

    // ****************************************
    // checks
    // ****************************************
    no_overlap_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !$past(force_i) |-> !(main_o && comp_o))
        else $error("main and complement both on");
    dead_gap_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (ref_i != st_reg.ref_prev) && !force_i && dt_i != `ACT_DT_ZERO
        |=> !main_o && !comp_o)
        else $error("no dead time after edge");
    brake_safe_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        force_i |=> main_o == $past(safe_main_i) &&
            comp_o == $past(safe_comp_i))
        else $error("outputs not at safe level");
endmodule
`default_nettype wire

// [design/act_timer.sv]
// Operation
// - counter advances once per prescale factor, any value 1 to 65536.
// - external trigger can reset, gate or start the counter.
// - active brake forces all outputs to software safe levels.
// - each pair gives main and inverse with programmable dead time.
// - separate events for four channels, update and brake.
// - centre mode counts up then down with complementary outputs.
// - an instance with TRIGGER_EN set pulses its trigger output on each update.
// - sixteen-bit counter with four capture or compare channels.
`timescale 1ns/1ps
`default_nettype none
`include "act_regs.svh"
module act_timer #(
    parameter bit TRIGGER_EN = 1'b1
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire logic [`ACT_CNT_W-1:0] prescale_i,
    input wire logic [`ACT_CNT_W-1:0] reload_i,
    input wire act_pkg::act_mode_type count_mode_i,
    input wire act_pkg::act_slave_type slave_mode_i,
    input wire logic [`ACT_CH*`ACT_CNT_W-1:0] compare_i,
    input wire logic [`ACT_CH-1:0] chan_output_i,
    input wire logic [`ACT_DT_W-1:0] deadtime_i,
    input wire logic [`ACT_CH-1:0] safe_main_i,
    input wire logic [`ACT_CH-1:0] safe_comp_i,
    input wire logic brake_rearm_i,
    input wire logic brake_input_i,
    input wire logic ext_trigger_i,
    input wire logic [`ACT_CH-1:0] capture_i,
    output logic [`ACT_CNT_W-1:0] count_o,
    output logic dir_o,
    output logic [`ACT_CH-1:0] pwm_o,
    output logic [`ACT_CH-1:0] pwm_n_o,
    output logic [`ACT_CH*`ACT_CNT_W-1:0] capture_value_o,
    output logic [`ACT_CH-1:0] event_cc_o,
    output logic event_update_o,
    output logic event_brake_o,
    output logic timer_trigger_output_o
);
    // ****************************************
    // state
    // ****************************************
    act_pkg::act_state_type st_reg;
    act_pkg::act_state_type st_next;
    logic trg_rise;
    logic run;
    logic tick;
    logic enc_a_chg;
    logic enc_b_chg;
    logic enc_up;
    logic enc_dn;
    logic force_safe;
    logic [`ACT_CH-1:0] cap_rise;

    function automatic logic [`ACT_CNT_W-1:0] ccr(
        input logic [`ACT_CH*`ACT_CNT_W-1:0] all,
        input integer idx
    );
        ccr = all[idx*`ACT_CNT_W +: `ACT_CNT_W];
    endfunction

    // edges only from second-stage flops, never the first
    assign trg_rise = st_reg.trg_s2 & ~st_reg.trg_prev;
    assign cap_rise = st_reg.cap_s2 & ~st_reg.cap_prev;
    assign run = enable_i
        & ~(slave_mode_i == act_pkg::ACT_SLAVE_GATE & ~st_reg.trg_s2)
        & ~(slave_mode_i == act_pkg::ACT_SLAVE_START & ~st_reg.started);
    assign tick = run & (st_reg.psc == prescale_i);
    assign enc_a_chg = st_reg.cap_s2[0] ^ st_reg.cap_prev[0];
    assign enc_b_chg = st_reg.cap_s2[1] ^ st_reg.cap_prev[1];
    assign enc_up = run & ((enc_a_chg & (st_reg.cap_s2[0] ^ st_reg.cap_s2[1]))
        | (enc_b_chg & ~(st_reg.cap_s2[0] ^ st_reg.cap_s2[1])));
    assign enc_dn = run & (enc_a_chg | enc_b_chg) & ~enc_up;
    // brake seen from the synchroniser directly saves a cycle
    assign force_safe = st_reg.brk_s2 | (st_reg.brk != act_pkg::ACT_BRK_RUN);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        st_next.brk_s1 = brake_input_i;
        st_next.brk_s2 = st_reg.brk_s1;
        st_next.trg_s1 = ext_trigger_i;
        st_next.trg_s2 = st_reg.trg_s1;
        st_next.trg_prev = st_reg.trg_s2;
        st_next.cap_s1 = capture_i;
        st_next.cap_s2 = st_reg.cap_s1;
        st_next.cap_prev = st_reg.cap_s2;
        st_next.irq_upd = 1'b0;
        st_next.irq_brk = 1'b0;
        if (!enable_i) begin
            st_next.started = 1'b0;
        end else if (slave_mode_i == act_pkg::ACT_SLAVE_START && trg_rise) begin
            st_next.started = 1'b1;
        end
        if (slave_mode_i == act_pkg::ACT_SLAVE_RESET && trg_rise) begin
            st_next.psc = `ACT_CNT_ZERO;
            st_next.cnt = (count_mode_i == act_pkg::ACT_MODE_DOWN) ?
                reload_i : `ACT_CNT_ZERO;
            st_next.dir = 1'b0;
        end else if (count_mode_i == act_pkg::ACT_MODE_ENCODER) begin
            // quadrature edges bypass the prescaler
            if (enc_up) begin
                st_next.dir = 1'b0;
                st_next.irq_upd = st_reg.cnt >= reload_i;
                st_next.cnt = (st_reg.cnt >= reload_i) ? `ACT_CNT_ZERO :
                    st_reg.cnt + `ACT_CNT_ONE;
            end else if (enc_dn) begin
                st_next.dir = 1'b1;
                st_next.irq_upd = st_reg.cnt == `ACT_CNT_ZERO;
                st_next.cnt = (st_reg.cnt == `ACT_CNT_ZERO) ? reload_i :
                    st_reg.cnt - `ACT_CNT_ONE;
            end
        end else if (run) begin
            st_next.psc = tick ? `ACT_CNT_ZERO :
                st_reg.psc + `ACT_CNT_ONE;
            if (tick) begin
                case (count_mode_i)
                    act_pkg::ACT_MODE_DOWN: begin
                        st_next.dir = 1'b1;
                        st_next.irq_upd = st_reg.cnt == `ACT_CNT_ZERO;
                        st_next.cnt = (st_reg.cnt == `ACT_CNT_ZERO) ?
                            reload_i : st_reg.cnt - `ACT_CNT_ONE;
                    end
                    act_pkg::ACT_MODE_CENTRE: begin
                        if (!st_reg.dir && st_reg.cnt >= reload_i) begin
                            st_next.dir = reload_i != `ACT_CNT_ZERO;
                            st_next.irq_upd = 1'b1;
                            st_next.cnt = (reload_i == `ACT_CNT_ZERO) ?
                                `ACT_CNT_ZERO : st_reg.cnt - `ACT_CNT_ONE;
                        end else if (st_reg.dir &&
                                st_reg.cnt == `ACT_CNT_ZERO) begin
                            st_next.dir = 1'b0;
                            st_next.irq_upd = 1'b1;
                            st_next.cnt = `ACT_CNT_ONE;
                        end else begin
                            st_next.cnt = st_reg.dir ?
                                st_reg.cnt - `ACT_CNT_ONE :
                                st_reg.cnt + `ACT_CNT_ONE;
                        end
                    end
                    default: begin
                        st_next.dir = 1'b0;
                        st_next.irq_upd = st_reg.cnt >= reload_i;
                        st_next.cnt = (st_reg.cnt >= reload_i) ?
                            `ACT_CNT_ZERO : st_reg.cnt + `ACT_CNT_ONE;
                    end
                endcase
            end
        end
        for (int i = 0; i < `ACT_CH; i++) begin
            if (chan_output_i[i]) begin
                st_next.pwm[i] = st_next.cnt < ccr(compare_i, i);
                st_next.irq_cc[i] = tick &
                    (st_reg.cnt == ccr(compare_i, i));
            end else begin
                st_next.pwm[i] = 1'b0;
                st_next.irq_cc[i] = cap_rise[i];
                if (cap_rise[i]) begin
                    st_next.cap_val[i] = st_reg.cnt;
                end
            end
        end
        st_next.trig = TRIGGER_EN & st_next.irq_upd;
        case (st_reg.brk)
            act_pkg::ACT_BRK_RUN: begin
                if (st_reg.brk_s2) begin
                    st_next.brk = act_pkg::ACT_BRK_FORCE;
                    st_next.irq_brk = 1'b1;
                end
            end
            act_pkg::ACT_BRK_FORCE: begin
                if (!st_reg.brk_s2) begin
                    st_next.brk = act_pkg::ACT_BRK_HOLD;
                end
            end
            act_pkg::ACT_BRK_HOLD: begin
                // outputs stay safe until software re-arms
                if (st_reg.brk_s2) begin
                    st_next.brk = act_pkg::ACT_BRK_FORCE;
                end else if (brake_rearm_i) begin
                    st_next.brk = act_pkg::ACT_BRK_RUN;
                end
            end
            default: begin
                st_next.brk = act_pkg::ACT_BRK_FORCE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // complementary outputs
    // ****************************************
    for (genvar g = 0; g < `ACT_CH; g++) begin : g_pair
        act_deadtime u_dt (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .ref_i(st_reg.pwm[g]),
            .dt_i(deadtime_i),
            .force_i(force_safe),
            .safe_main_i(safe_main_i[g]),
            .safe_comp_i(safe_comp_i[g]),
            .main_o(pwm_o[g]),
            .comp_o(pwm_n_o[g])
        );
    end

    if (TRIGGER_EN !== 1'b0 && TRIGGER_EN !== 1'b1) begin : g_chk
        $error("trigger enable must be 0 or 1");
    end

    assign count_o = st_reg.cnt;
    assign dir_o = st_reg.dir;
    assign capture_value_o = st_reg.cap_val;
    assign event_cc_o = st_reg.irq_cc;
    assign event_update_o = st_reg.irq_upd;
    assign event_brake_o = st_reg.irq_brk;
    assign timer_trigger_output_o = st_reg.trig;

    // ****************************************
    // checks
    // ****************************************
    psc_wrap_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        run && count_mode_i != act_pkg::ACT_MODE_ENCODER &&
        slave_mode_i != act_pkg::ACT_SLAVE_RESET && !tick
        |=> st_reg.psc == $past(st_reg.psc) + `ACT_CNT_ONE &&
            st_reg.cnt == $past(st_reg.cnt))
        else $error("counter moved between prescale ticks");
    slave_reset_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        slave_mode_i == act_pkg::ACT_SLAVE_RESET && trg_rise &&
        count_mode_i == act_pkg::ACT_MODE_UP
        |=> count_o == `ACT_CNT_ZERO)
        else $error("trigger did not reset counter");
    brake_enter_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        st_reg.brk == act_pkg::ACT_BRK_RUN && st_reg.brk_s2
        |=> event_brake_o ##1 st_reg.brk != act_pkg::ACT_BRK_RUN)
        else $error("brake not taken");
    capture_val_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !chan_output_i[2] && cap_rise[2]
        |=> event_cc_o[2] &&
            capture_value_o[2*`ACT_CNT_W +: `ACT_CNT_W] == $past(count_o))
        else $error("capture value or event wrong");
    centre_turn_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        count_mode_i == act_pkg::ACT_MODE_CENTRE && tick && !dir_o &&
        count_o >= reload_i && reload_i != `ACT_CNT_ZERO &&
        slave_mode_i != act_pkg::ACT_SLAVE_RESET
        |=> dir_o && event_update_o)
        else $error("centre mode did not turn down");
    trig_out_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        event_update_o |-> timer_trigger_output_o == TRIGGER_EN)
        else $error("trigger output does not follow update");
    up_wrap_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        count_mode_i == act_pkg::ACT_MODE_UP && tick &&
        count_o == reload_i && slave_mode_i != act_pkg::ACT_SLAVE_RESET
        |=> count_o == `ACT_CNT_ZERO && event_update_o)
        else $error("up count did not wrap at reload");
    enc_step_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        count_mode_i == act_pkg::ACT_MODE_ENCODER && enc_dn &&
        count_o != `ACT_CNT_ZERO && slave_mode_i != act_pkg::ACT_SLAVE_RESET
        |=> count_o == $past(count_o) - `ACT_CNT_ONE && dir_o)
        else $error("encoder step down wrong");
endmodule
`default_nettype wire

// [verification/act_stage_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// power stage, encoder and pin sources
// ****************************************
module act_stage_model (
    input wire logic clk_i,
    input wire logic [3:0] pwm_i,
    input wire logic [3:0] pwm_n_i,
    output logic brake_o,
    output logic trigger_o,
    output logic [3:0] cap_o,
    output logic shoot_o
);
    int q;

    // the stage flags any pair driven high on both sides at once
    assign shoot_o = |(pwm_i & pwm_n_i);

    initial begin
        brake_o = 1'b0;
        trigger_o = 1'b0;
        cap_o = 4'h0;
        q = 0;
    end

    task automatic set_brake(input logic v);
        @(negedge clk_i);
        brake_o = v;
    endtask

    task automatic set_trigger(input logic v);
        @(negedge clk_i);
        trigger_o = v;
    endtask

    task automatic set_cap(input int ch, input logic v);
        @(negedge clk_i);
        cap_o[ch] = v;
    endtask

    // gray steps held four cycles so the two sync flops always see them
    task automatic quad_step(input logic fwd);
        @(negedge clk_i);
        q = fwd ? (q + 1) % 4 : (q + 3) % 4;
        cap_o[0] = (q == 1) || (q == 2);
        cap_o[1] = (q == 2) || (q == 3);
        repeat (3) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// [verification/advanced_control_timer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        check_count++; \
        if ((got) !== (ex)) begin \
            $display("wrong value %s exp %0h got %0h", nm, ex, got); \
            bad_count++; \
        end \
    end
`define WAIT_FOR(cond, lim) \
    begin \
        n = 0; \
        while (!(cond) && n < (lim)) begin \
            @(negedge clk_i); \
            n++; \
        end \
        if (n >= (lim)) timeout(); \
    end
module advanced_control_timer_tb;
    logic clk_i, reset_i, enable_i, brake_rearm_i;
    logic brake_input_i, ext_trigger_i, shoot;
    logic [15:0] prescale_i, reload_i, count_o;
    act_pkg::act_mode_type count_mode_i;
    act_pkg::act_slave_type slave_mode_i;
    logic [63:0] compare_i, capture_value_o;
    logic [3:0] chan_output_i, safe_main_i, safe_comp_i, capture_i;
    logic [3:0] pwm_o, pwm_n_o, event_cc_o;
    logic [7:0] deadtime_i;
    logic dir_o, event_update_o, event_brake_o, timer_trigger_output_o;
    int bad_count, check_count, n;

    act_timer #(.TRIGGER_EN(1'b1)) u_dut (
        .clk_i(clk_i), .reset_i(reset_i), .enable_i(enable_i),
        .prescale_i(prescale_i), .reload_i(reload_i),
        .count_mode_i(count_mode_i), .slave_mode_i(slave_mode_i),
        .compare_i(compare_i), .chan_output_i(chan_output_i),
        .deadtime_i(deadtime_i), .safe_main_i(safe_main_i),
        .safe_comp_i(safe_comp_i), .brake_rearm_i(brake_rearm_i),
        .brake_input_i(brake_input_i), .ext_trigger_i(ext_trigger_i),
        .capture_i(capture_i), .count_o(count_o), .dir_o(dir_o),
        .pwm_o(pwm_o), .pwm_n_o(pwm_n_o),
        .capture_value_o(capture_value_o), .event_cc_o(event_cc_o),
        .event_update_o(event_update_o), .event_brake_o(event_brake_o),
        .timer_trigger_output_o(timer_trigger_output_o)
    );

    act_stage_model u_far (
        .clk_i(clk_i), .pwm_i(pwm_o), .pwm_n_i(pwm_n_o),
        .brake_o(brake_input_i), .trigger_o(ext_trigger_i),
        .cap_o(capture_i), .shoot_o(shoot)
    );

    // ****************************************
    // run control
    // ****************************************
    task automatic conclude();
        if (bad_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic timeout();
        bad_count++;
        $display("wrong value wait exp done got timeout");
        conclude();
    endtask

    always @(negedge clk_i) begin
        if (!reset_i) `CHK("overlap", 1'b0, shoot);
    end

    // reset between scenarios so each starts from a known count
    task automatic cfg(input act_pkg::act_mode_type md,
            input act_pkg::act_slave_type sl, input logic [15:0] ps,
            input logic [15:0] rl);
        @(negedge clk_i);
        reset_i = 1'b1;
        count_mode_i = md;
        slave_mode_i = sl;
        prescale_i = ps;
        reload_i = rl;
        repeat (2) @(negedge clk_i);
        reset_i = 1'b0;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic run_period(input act_pkg::act_mode_type md,
            input logic [15:0] ps, input logic [15:0] rl, input int per,
            input logic [15:0] at);
        logic d;
        cfg(md, act_pkg::ACT_SLAVE_OFF, ps, rl);
        `WAIT_FOR(event_update_o === 1'b1, 300)
        d = dir_o;
        `CHK("trigger", 1'b1, timer_trigger_output_o);
        if (md != act_pkg::ACT_MODE_CENTRE) `CHK("wrap", at, count_o);
        @(negedge clk_i);
        `CHK("update pulse", 1'b0, event_update_o);
        `WAIT_FOR(event_update_o === 1'b1, 300)
        `CHK("period", per, n + 1);
        if (md == act_pkg::ACT_MODE_CENTRE) `CHK("dir", ~d, dir_o);
    endtask

    task automatic slave_case(input act_pkg::act_slave_type sl);
        logic [15:0] c;
        cfg(act_pkg::ACT_MODE_UP, sl, 16'h0000, 16'h00c8);
        repeat (10) @(negedge clk_i);
        `CHK("held count", 16'h0000, count_o);
        u_far.set_trigger(1'b1);
        repeat (10) @(negedge clk_i);
        `CHK("running", 1'b1, count_o != 16'h0000);
        u_far.set_trigger(1'b0);
        repeat (4) @(negedge clk_i);
        c = count_o;
        repeat (5) @(negedge clk_i);
        `CHK("after low", (sl == act_pkg::ACT_SLAVE_GATE) ? c : c + 16'h0005,
            count_o);
        // dropping the enable also forgets a seen start trigger
        enable_i = 1'b0;
        c = count_o;
        repeat (5) @(negedge clk_i);
        enable_i = 1'b1;
        repeat (5) @(negedge clk_i);
        `CHK("disabled", c, count_o);
    endtask

    task automatic reset_case();
        cfg(act_pkg::ACT_MODE_UP, act_pkg::ACT_SLAVE_RESET, 16'h0000,
            16'h00c8);
        repeat (40) @(negedge clk_i);
        u_far.set_trigger(1'b1);
        `WAIT_FOR(count_o === 16'h0000, 6)
        `CHK("trigger reset", 16'h0000, count_o);
        u_far.set_trigger(1'b0);
    endtask

    // safe levels must never be high on both sides of one pair
    task automatic pwm_case(input logic [7:0] dt, input logic [15:0] cmp,
            input logic [3:0] sm, input logic [3:0] sc);
        deadtime_i = dt;
        compare_i = {4{cmp}};
        safe_main_i = sm;
        safe_comp_i = sc;
        cfg(act_pkg::ACT_MODE_UP, act_pkg::ACT_SLAVE_OFF, 16'h0000, 16'h0013);
        `WAIT_FOR(event_cc_o[0] === 1'b1, 40)
        `CHK("compare event", 1'b1, event_cc_o[0]);
        u_far.set_brake(1'b1);
        `WAIT_FOR(event_brake_o === 1'b1, 5)
        `CHK("safe main", sm, pwm_o);
        `CHK("safe comp", sc, pwm_n_o);
        @(negedge clk_i);
        `CHK("brake pulse", 1'b0, event_brake_o);
        u_far.set_brake(1'b0);
        repeat (10) @(negedge clk_i);
        `CHK("held safe", sm, pwm_o);
        brake_rearm_i = 1'b1;
        @(negedge clk_i);
        brake_rearm_i = 1'b0;
        `WAIT_FOR(pwm_n_o[0] === 1'b1, 60)
        `WAIT_FOR(pwm_n_o[0] === 1'b0, 60)
        `WAIT_FOR(pwm_o[0] === 1'b1, 20)
        `CHK("dead time", dt, n);
        `WAIT_FOR(pwm_o[0] === 1'b0, 40)
        `CHK("main width", cmp - dt, n);
    endtask

    task automatic encoder_case();
        cfg(act_pkg::ACT_MODE_ENCODER, act_pkg::ACT_SLAVE_OFF, 16'h0000,
            16'h0064);
        chan_output_i = 4'hb;
        repeat (5) u_far.quad_step(1'b1);
        repeat (2) u_far.quad_step(1'b0);
        repeat (4) @(negedge clk_i);
        `CHK("encoder count", 16'h0003, count_o);
        repeat (4) u_far.quad_step(1'b0);
        repeat (4) @(negedge clk_i);
        `CHK("encoder wrap", 16'h0064, count_o);
        u_far.set_cap(2, 1'b1);
        `WAIT_FOR(event_cc_o[2] === 1'b1, 8)
        `CHK("captured", 16'h0064, capture_value_o[47:32]);
        u_far.set_cap(2, 1'b0);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        bad_count = 0;
        check_count = 0;
        reset_i = 1'b1;
        enable_i = 1'b1;
        brake_rearm_i = 1'b0;
        prescale_i = 16'h0000;
        reload_i = 16'h0013;
        count_mode_i = act_pkg::ACT_MODE_UP;
        slave_mode_i = act_pkg::ACT_SLAVE_OFF;
        compare_i = {4{16'h000a}};
        chan_output_i = 4'hf;
        deadtime_i = 8'h03;
        safe_main_i = 4'h5;
        safe_comp_i = 4'ha;
        repeat (12) @(negedge clk_i);
        reset_i = 1'b0;
        run_period(act_pkg::ACT_MODE_UP, 16'h0002, 16'h0004, 15, 16'h0000);
        run_period(act_pkg::ACT_MODE_UP, 16'h0000, 16'h0003, 4, 16'h0000);
        run_period(act_pkg::ACT_MODE_DOWN, 16'h0001, 16'h0005, 12, 16'h0005);
        run_period(act_pkg::ACT_MODE_CENTRE, 16'h0001, 16'h0006, 12,
            16'h0000);
        slave_case(act_pkg::ACT_SLAVE_GATE);
        slave_case(act_pkg::ACT_SLAVE_START);
        reset_case();
        pwm_case(8'h03, 16'h000a, 4'h5, 4'ha);
        pwm_case(8'h02, 16'h0006, 4'h9, 4'h6);
        encoder_case();
        conclude();
    end
endmodule
`default_nettype wire
